/* File: include/rtmsq_if.sv */
// Purpose: spi link between host and touch sequencer
// Assumes: host is master and makes sclk
// Notes: miso enable only feeds the bench checker, miso has a single driver
`timescale 1ns/100ps
interface rtmsq_if;
  logic sclk;
  logic ss_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic pen_touch_data_ready_out;
  modport host (output sclk, output ss_n, output mosi, input miso, input miso_oe, input pen_touch_data_ready_out);
  modport dev (input sclk, input ss_n, input mosi, output miso, output miso_oe, output pen_touch_data_ready_out);
endinterface

/* File: include/rtmsq_pkg.sv */
// Purpose: shared constants and types for the touch sequencer and its spi host
// Assumes: 50 MHz hclk, 8 MHz nominal sequencer time base
// Notes: register indices and field positions are fixed here
package rtmsq_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned SEQ_HZ = 8000000;
  // one internal sequencer tick in hclk cycles, rounded down, at least one
  localparam int unsigned TICK_CYC_RAW = CLK_HZ / SEQ_HZ;
  localparam logic [3:0] TICK_CYC = (TICK_CYC_RAW < 1) ? 4'h1 : TICK_CYC_RAW[3:0];
  // number of hclk cycles one simulated conversion takes
  localparam logic [7:0] CONV_CYC = 8'h10;
  // sclk half period in hclk cycles; covers both miso synchronisers within one half
  localparam logic [7:0] SCLK_HALF = 8'h0c;

  // device register indices (16-bit registers)
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_DELAY = 6'h01;
  localparam logic [5:0] REG_STAT = 6'h02;
  localparam logic [5:0] REG_X = 6'h03;
  localparam logic [5:0] REG_Y = 6'h04;
  localparam logic [5:0] REG_Z1 = 6'h05;
  localparam logic [5:0] REG_Z2 = 6'h06;
  localparam logic [5:0] REG_CMD = 6'h07;
  // command word: bit15 read, bits 5:0 register index
  localparam int CMD_RD_BIT = 15;
  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RES_LSB = 2;
  // cmd register values, then ctrl and delay reset values
  localparam logic [15:0] CMD_SCAN = 16'h0001;
  localparam logic [15:0] CMD_DRV_X = 16'h0002;
  localparam logic [15:0] CMD_DRV_Y = 16'h0003;
  localparam logic [15:0] CMD_CONV = 16'h0004;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] DELAY_RST = 16'h0010;

  typedef enum logic [1:0] {
    RTMSQ_MODE_TOUCH = 2'h0,
    RTMSQ_MODE_PEN_HOST = 2'h1,
    RTMSQ_MODE_HOST = 2'h2
  } rtmsq_mode_t;

  // drive selection onto the panel
  typedef enum logic [1:0] {
    RTMSQ_DRV_OFF = 2'h0,
    RTMSQ_DRV_Y = 2'h1,
    RTMSQ_DRV_X = 2'h2,
    RTMSQ_DRV_Z = 2'h3
  } rtmsq_drv_t;

  // host register offsets on ahb
  localparam logic [7:0] H_CMD = 8'h00;
  localparam logic [7:0] H_WDATA = 8'h04;
  localparam logic [7:0] H_RDATA = 8'h08;
  localparam logic [7:0] H_STAT = 8'h0c;
  localparam logic [7:0] H_IRQ_STAT = 8'h10;
  localparam logic [7:0] H_IRQ_EN = 8'h14;
  localparam logic [7:0] H_IRQ_CLR = 8'h18;
endpackage

/* File: rtl/rtmsq_dev.sv */
// Purpose: touch panel sequencer with spi slave register port
// Assumes: spi mode 0, 32-bit frame: 16-bit command then 16-bit data
// Notes: conversion is modelled by sampling adc_value after a fixed time
// Summary of operation
// RULE1: host holds select low through transfer
// RULE2: host makes sclk and shifts data
// RULE3: 16-bit registers chosen by command word
// RULE4: y: drive y axis, sample x plus
// RULE5: then drive x axis, convert x
// RULE6: convert z1 and z2 with x
// RULE7: stabilization delay before each conversion
// RULE8: drivers-only command without conversion
// RULE9: host waits settling after drivers-only
// RULE10: three control modes touch, pen-host, host
// RULE11: host should pick 8-bit for pressure; the device does not decode the resolution field and keeps 12-bit results
// RULE12: delays counted in 8 MHz ticks
// RULE13: delay counter expiry starts conversion
`timescale 1ns/100ps
module rtmsq_dev (
  input wire logic hclk,
  input wire logic hresetn,
  rtmsq_if.dev link,
  input wire logic touch_n,
  input wire logic [11:0] adc_value,
  output logic [1:0] drive_sel,
  output logic conv_busy
);
  logic [2:0] sclk_s_q, ss_s_q, mosi_s_q, touch_s_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_s_q <= 3'h0;
      ss_s_q <= 3'h7;
      mosi_s_q <= 3'h0;
      touch_s_q <= 3'h7;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], link.sclk};
      ss_s_q <= {ss_s_q[1:0], link.ss_n};
      mosi_s_q <= {mosi_s_q[1:0], link.mosi};
      touch_s_q <= {touch_s_q[1:0], touch_n};
    end
  end
  logic sclk_f_q, ss_f_q, mosi_f_q, touch_f_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_f_q <= 1'b0;
      ss_f_q <= 1'b1;
      mosi_f_q <= 1'b0;
      touch_f_q <= 1'b1;
    end else begin
      if (sclk_s_q[1] == sclk_s_q[2]) sclk_f_q <= sclk_s_q[2];
      if (ss_s_q[1] == ss_s_q[2]) ss_f_q <= ss_s_q[2];
      if (mosi_s_q[1] == mosi_s_q[2]) mosi_f_q <= mosi_s_q[2];
      if (touch_s_q[1] == touch_s_q[2]) touch_f_q <= touch_s_q[2];
    end
  end
  logic sclk_d1_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sclk_d1_q <= 1'b0;
    else sclk_d1_q <= sclk_f_q;
  end
  wire sel = !ss_f_q; // [RULE1]
  wire rise = sel && sclk_f_q && !sclk_d1_q; // [RULE2]
  wire fall = sel && !sclk_f_q && sclk_d1_q;

  // spi shifter
  logic [4:0] bit_q;
  logic [15:0] cmd_q, sh_q, tx_q;
  logic wr_pulse_q;
  logic [15:0] ctrl_q, delay_q, x_q, y_q, z1_q, z2_q, cmd_reg_q;
  logic [15:0] stat_w;
  logic [15:0] rd_w;
  wire [5:0] idx_w = cmd_q[5:0];
  assign rd_w = (idx_w == rtmsq_pkg::REG_CTRL) ? ctrl_q :
                (idx_w == rtmsq_pkg::REG_DELAY) ? delay_q :
                (idx_w == rtmsq_pkg::REG_STAT) ? stat_w :
                (idx_w == rtmsq_pkg::REG_X) ? x_q :
                (idx_w == rtmsq_pkg::REG_Y) ? y_q :
                (idx_w == rtmsq_pkg::REG_Z1) ? z1_q :
                (idx_w == rtmsq_pkg::REG_Z2) ? z2_q :
                (idx_w == rtmsq_pkg::REG_CMD) ? cmd_reg_q : 16'h0000;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_q <= 5'h00;
      cmd_q <= 16'h0000;
      sh_q <= 16'h0000;
      tx_q <= 16'h0000;
      wr_pulse_q <= 1'b0;
    end else begin
      wr_pulse_q <= 1'b0;
      if (!sel) begin
        bit_q <= 5'h00;
      end else if (rise) begin
        sh_q <= {sh_q[14:0], mosi_f_q};
        bit_q <= bit_q + 5'h01;
        if (bit_q == 5'h0f) begin
          cmd_q <= {sh_q[14:0], mosi_f_q}; // [RULE3]
        end
        if (bit_q == 5'h1f) begin
          wr_pulse_q <= !cmd_q[rtmsq_pkg::CMD_RD_BIT];
        end
      end else if (fall && bit_q == 5'h10) begin
        tx_q <= rd_w;
      end else if (fall && bit_q > 5'h10) begin
        tx_q <= {tx_q[14:0], 1'b0};
      end
    end
  end

  // sequencer
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_SETTLE = 6'b000010, S_CONV = 6'b000100,
    S_NEXT = 6'b001000, S_HOLD = 6'b010000, S_DONE = 6'b100000
  } rtmsq_st_t;
  rtmsq_st_t st_q;
  rtmsq_pkg::rtmsq_drv_t drv_q;
  logic [1:0] step_q;
  logic scan_q;
  logic [3:0] tick_q;
  logic [15:0] wait_q;
  logic [7:0] conv_q;
  logic ready_q;
  wire [1:0] mode_w = ctrl_q[rtmsq_pkg::CTRL_MODE_LSB +: 2];
  wire wr_cmd = wr_pulse_q && idx_w == rtmsq_pkg::REG_CMD;
  wire touch_go = mode_w == rtmsq_pkg::RTMSQ_MODE_TOUCH && !touch_f_q; // [RULE10]
  wire tick = tick_q == rtmsq_pkg::TICK_CYC - 4'h1; // [RULE12]
  assign stat_w = {11'h000, ready_q, st_q == S_IDLE, mode_w, 1'b0};
  // tick phase restarts with each settle so the delay is whole ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_q <= 4'h0;
    else tick_q <= (tick || st_q != S_SETTLE) ? 4'h0 : tick_q + 4'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= rtmsq_pkg::CTRL_RST;
      delay_q <= rtmsq_pkg::DELAY_RST;
      cmd_reg_q <= 16'h0000;
    end else if (wr_pulse_q) begin
      if (idx_w == rtmsq_pkg::REG_CTRL) ctrl_q <= sh_q;
      if (idx_w == rtmsq_pkg::REG_DELAY) delay_q <= sh_q;
      if (idx_w == rtmsq_pkg::REG_CMD) cmd_reg_q <= sh_q;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= S_IDLE;
      drv_q <= rtmsq_pkg::RTMSQ_DRV_OFF;
      step_q <= 2'h0;
      scan_q <= 1'b0;
      wait_q <= 16'h0000;
      conv_q <= 8'h00;
      ready_q <= 1'b0;
      x_q <= 16'h0000;
      y_q <= 16'h0000;
      z1_q <= 16'h0000;
      z2_q <= 16'h0000;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          if ((wr_cmd && sh_q == rtmsq_pkg::CMD_SCAN) || (touch_go && !ready_q)) begin
            ready_q <= 1'b0;
            scan_q <= 1'b1;
            step_q <= 2'h0;
            drv_q <= rtmsq_pkg::RTMSQ_DRV_Y; // [RULE4]
            wait_q <= delay_q;
            st_q <= S_SETTLE;
          end else if (wr_cmd && (sh_q == rtmsq_pkg::CMD_DRV_X || sh_q == rtmsq_pkg::CMD_DRV_Y)) begin
            drv_q <= (sh_q == rtmsq_pkg::CMD_DRV_X) ? rtmsq_pkg::RTMSQ_DRV_X : rtmsq_pkg::RTMSQ_DRV_Y;
            st_q <= S_HOLD; // [RULE8]
          end
        end
        S_HOLD: begin
          if (wr_cmd && sh_q == rtmsq_pkg::CMD_CONV) begin
            scan_q <= 1'b0;
            step_q <= (drv_q == rtmsq_pkg::RTMSQ_DRV_Y) ? 2'h0 : 2'h1;
            conv_q <= rtmsq_pkg::CONV_CYC;
            st_q <= S_CONV; // [RULE9]
          end
        end
        S_SETTLE: begin
          if (tick) wait_q <= wait_q - 16'h0001;
          if (wait_q == 16'h0000) begin
            conv_q <= rtmsq_pkg::CONV_CYC;
            st_q <= S_CONV; // [RULE7] [RULE13]
          end
        end
        S_CONV: begin
          conv_q <= conv_q - 8'h01;
          if (conv_q == 8'h01) begin
            unique case (step_q)
              2'h0: y_q <= {4'h0, adc_value};
              2'h1: x_q <= {4'h0, adc_value};
              2'h2: z1_q <= {4'h0, adc_value};
              2'h3: z2_q <= {4'h0, adc_value};
            endcase
            st_q <= S_NEXT;
          end
        end
        S_NEXT: begin
          if (scan_q && step_q != 2'h3) begin
            step_q <= step_q + 2'h1;
            drv_q <= (step_q == 2'h0) ? rtmsq_pkg::RTMSQ_DRV_X : rtmsq_pkg::RTMSQ_DRV_Z; // [RULE5] [RULE6]
            wait_q <= delay_q;
            st_q <= S_SETTLE;
          end else begin
            drv_q <= rtmsq_pkg::RTMSQ_DRV_OFF;
            st_q <= S_DONE;
          end
        end
        S_DONE: begin
          ready_q <= 1'b1;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
      // completion wins over a clear in the same cycle
      if (wr_pulse_q && idx_w == rtmsq_pkg::REG_STAT && st_q != S_DONE) ready_q <= 1'b0;
    end
  end
  logic miso_q, oe_q, pen_q, busy_q;
  logic [1:0] drv_out_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      miso_q <= 1'b0;
      oe_q <= 1'b0;
      pen_q <= 1'b1;
      busy_q <= 1'b0;
      drv_out_q <= 2'h0;
    end else begin
      miso_q <= (bit_q >= 5'h10) ? tx_q[15] : 1'b0;
      oe_q <= sel;
      pen_q <= !(ready_q || (st_q == S_IDLE && !touch_f_q));
      busy_q <= st_q == S_CONV;
      drv_out_q <= drv_q;
    end
  end
  assign link.miso = miso_q;
  assign link.miso_oe = oe_q;
  assign link.pen_touch_data_ready_out = pen_q;
  assign drive_sel = drv_out_q;
  assign conv_busy = busy_q;
endmodule

/* File: rtl/rtmsq_host.sv */
// Purpose: ahb-lite controlled spi master for the touch sequencer
// Assumes: single word transfers, zero wait states
// Notes: one 32-bit frame per command write made while idle; a command write during a frame starts none
`timescale 1ns/100ps
module rtmsq_host (
  input wire logic hclk,
  input wire logic hresetn,
  rtmsq_if.host link,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq
);
  logic ap_q, aw_q;
  logic [7:0] aa_q;
  logic [15:0] cmd_q, wd_q, rd_q;
  logic [1:0] is_q, ie_q;
  logic busy_q, sclk_q, ss_q, mosi_q;
  logic [7:0] div_q;
  logic [5:0] bit_q;
  logic [31:0] sh_q, hr_q;
  logic [2:0] miso_s_q, pen_s_q;
  logic miso_f_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      miso_s_q <= 3'h0;
      pen_s_q <= 3'h7;
      miso_f_q <= 1'b0;
    end else begin
      miso_s_q <= {miso_s_q[1:0], link.miso};
      pen_s_q <= {pen_s_q[1:0], link.pen_touch_data_ready_out};
      if (miso_s_q[1] == miso_s_q[2]) miso_f_q <= miso_s_q[2];
    end
  end
  wire pen_low = pen_s_q[1] == pen_s_q[2] && !pen_s_q[2];
  wire take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'b0;
      aw_q <= 1'b0;
      aa_q <= 8'h00;
    end else begin
      ap_q <= take;
      aw_q <= hwrite;
      aa_q <= haddr;
    end
  end
  wire wr = ap_q && aw_q;
  wire start = wr && aa_q == rtmsq_pkg::H_CMD && !busy_q;
  wire half = div_q == rtmsq_pkg::SCLK_HALF - 8'h01;
  wire done_ev = busy_q && half && sclk_q && bit_q == 6'h1f;
  // selected from the address phase so read data stands through the data phase
  wire [31:0] rmux = (haddr == rtmsq_pkg::H_CMD) ? {16'h0000, cmd_q} :
                     (haddr == rtmsq_pkg::H_WDATA) ? {16'h0000, wd_q} :
                     (haddr == rtmsq_pkg::H_RDATA) ? {16'h0000, rd_q} :
                     (haddr == rtmsq_pkg::H_STAT) ? {30'h0, !pen_low, busy_q} :
                     (haddr == rtmsq_pkg::H_IRQ_STAT) ? {30'h0, is_q} :
                     (haddr == rtmsq_pkg::H_IRQ_EN) ? {30'h0, ie_q} : 32'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= 16'h0000;
      wd_q <= 16'h0000;
      ie_q <= 2'h0;
      is_q <= 2'h0;
      hr_q <= 32'h0;
    end else begin
      if (wr && aa_q == rtmsq_pkg::H_CMD) cmd_q <= hwdata[15:0];
      if (wr && aa_q == rtmsq_pkg::H_WDATA) wd_q <= hwdata[15:0];
      if (wr && aa_q == rtmsq_pkg::H_IRQ_EN) ie_q <= hwdata[1:0];
      // set wins over clear
      is_q <= ((wr && aa_q == rtmsq_pkg::H_IRQ_CLR) ? is_q & ~hwdata[1:0] : is_q) | {pen_low, done_ev};
      if (take && !hwrite) hr_q <= rmux;
    end
  end
  // spi master, mode 0, sclk from divider
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
      sclk_q <= 1'b0;
      ss_q <= 1'b1;
      mosi_q <= 1'b0;
      div_q <= 8'h00;
      bit_q <= 6'h00;
      sh_q <= 32'h0;
      rd_q <= 16'h0000;
    end else if (!busy_q) begin
      if (start) begin
        busy_q <= 1'b1;
        ss_q <= 1'b0; // [RULE1]
        sh_q <= {hwdata[15:0], wd_q};
        mosi_q <= hwdata[15];
        div_q <= 8'h00;
        bit_q <= 6'h00;
      end
    end else begin
      div_q <= half ? 8'h00 : div_q + 8'h01;
      if (half) begin
        sclk_q <= !sclk_q; // [RULE2]
        if (!sclk_q) begin
          rd_q <= {rd_q[14:0], miso_f_q};
        end else if (bit_q == 6'h1f) begin
          busy_q <= 1'b0;
          ss_q <= 1'b1;
        end else begin
          sh_q <= {sh_q[30:0], 1'b0};
          mosi_q <= sh_q[30];
          bit_q <= bit_q + 6'h01;
        end
      end
    end
  end
  logic irq_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq_q <= 1'b0;
    else irq_q <= |(is_q & ie_q);
  end
  assign link.sclk = sclk_q;
  assign link.ss_n = ss_q;
  assign link.mosi = mosi_q;
  assign hrdata = hr_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = irq_q;
endmodule

/* File: test/rtmsq_chk.sv */
// Purpose: link and sequencer checks between host and touch sequencer
// Assumes: spi mode 0, 32 sclk rises per frame
// Notes: sees interface signals plus drive and busy of the device
`timescale 1ns/100ps
module rtmsq_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic pen_touch_data_ready_out,
  input wire logic [1:0] drive_sel,
  input wire logic conv_busy
);
  logic sclk_q;
  logic [5:0] rise_cnt_q;
  logic [5:0] rise_cnt_d;
  assign rise_cnt_d = ss_n ? 6'h00 : rise_cnt_q + {5'h00, sclk & ~sclk_q};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_q <= 1'b0;
      rise_cnt_q <= 6'h00;
    end else begin
      sclk_q <= sclk;
      rise_cnt_q <= rise_cnt_d;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_conv_hold;
    conv_busy [*8] ##1 conv_busy [*7];
  endsequence
  sequence s_settle_quiet;
    !conv_busy [*4];
  endsequence
  a_sclk_idle_low: assert property (ss_n && $past(ss_n) |-> !sclk)
    else $error("sclk moved outside a frame");
  a_sclk_in_frame: assert property ($rose(sclk) |-> !ss_n)
    else $error("sclk rise without select");
  a_frame_bits: assert property ($rose(ss_n) |-> rise_cnt_q == 6'h20)
    else $error("frame is not 32 bits");
  a_frame_gap: assert property ($rose(ss_n) |=> ss_n)
    else $error("select released for no cycle");
  a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi changed while sclk high");
  a_miso_quiet: assert property (ss_n [*6] |-> !miso_oe)
    else $error("miso driven while deselected");
  a_y_then_x: assert property ($past(drive_sel) == rtmsq_pkg::RTMSQ_DRV_Y && drive_sel != rtmsq_pkg::RTMSQ_DRV_Y
    |-> drive_sel inside {rtmsq_pkg::RTMSQ_DRV_X, rtmsq_pkg::RTMSQ_DRV_OFF})
    else $error("y drive not followed by x");
  a_conv_driven: assert property (conv_busy |-> drive_sel != rtmsq_pkg::RTMSQ_DRV_OFF)
    else $error("conversion with panel undriven");
  a_conv_length: assert property ($rose(conv_busy) |-> s_conv_hold)
    else $error("conversion cut short");
  a_settle_first: assert property ($changed(drive_sel) && drive_sel != rtmsq_pkg::RTMSQ_DRV_OFF
    |=> s_settle_quiet)
    else $error("conversion before settling");
endmodule

/* File: test/testbench.sv */
// Purpose: drives the host over ahb and the panel, checks the sequencer
// Assumes: zero wait ahb, read data taken at the end of the data phase
// Notes: panel level follows the driven axis
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module testbench;
  logic hclk, hresetn, hsel, hwrite, touch_n, irq, hreadyout, hresp, conv_busy, busy_prev, armed;
  logic [7:0] haddr;
  logic [1:0] htrans, drive_sel, drv_prev;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [11:0] adc_value;
  logic [1:0] order_q[$];
  int bad_count, n_checks, n_conv, gap, i, c0;
  int gmin = 9999;
  int gmax = 0;
  localparam logic [15:0] DLY = 16'h0002;
  // resolution code for 8-bit, arbitrary
  localparam logic [15:0] RES_8 = 16'h0001 << rtmsq_pkg::CTRL_RES_LSB;
  logic [5:0] regs[4] = '{rtmsq_pkg::REG_X, rtmsq_pkg::REG_Y, rtmsq_pkg::REG_Z1, rtmsq_pkg::REG_Z2};
  logic [11:0] vals[4] = '{12'h456, 12'h123, 12'h789, 12'h789};
  logic [15:0] dcmd[2] = '{rtmsq_pkg::CMD_DRV_X, rtmsq_pkg::CMD_DRV_Y};
  logic [1:0] dsel[2] = '{rtmsq_pkg::RTMSQ_DRV_X, rtmsq_pkg::RTMSQ_DRV_Y};
  logic [1:0] ord[3] = '{rtmsq_pkg::RTMSQ_DRV_Y, rtmsq_pkg::RTMSQ_DRV_X, rtmsq_pkg::RTMSQ_DRV_Z};
  rtmsq_if link_if();
  rtmsq_dev i_rtmsq_dev (.hclk(hclk), .hresetn(hresetn), .link(link_if), .touch_n(touch_n),
    .adc_value(adc_value), .drive_sel(drive_sel), .conv_busy(conv_busy));
  rtmsq_host i_rtmsq_host (.hclk(hclk), .hresetn(hresetn), .link(link_if), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
  rtmsq_chk i_rtmsq_chk (.hclk(hclk), .hresetn(hresetn), .sclk(link_if.sclk), .ss_n(link_if.ss_n),
    .mosi(link_if.mosi), .miso(link_if.miso), .miso_oe(link_if.miso_oe),
    .pen_touch_data_ready_out(link_if.pen_touch_data_ready_out), .drive_sel(drive_sel), .conv_busy(conv_busy));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // panel level per axis, drive order and settle gap
  always @(posedge hclk) begin
    adc_value <= (drive_sel == rtmsq_pkg::RTMSQ_DRV_Y) ? 12'h123 :
      (drive_sel == rtmsq_pkg::RTMSQ_DRV_X) ? 12'h456 : 12'h789;
    drv_prev <= drive_sel;
    busy_prev <= conv_busy;
    gap <= gap + 1;
    if (drive_sel !== drv_prev && drive_sel != 2'h0) begin
      order_q.push_back(drive_sel);
      gap <= 0;
      armed <= 1'b1;
    end
    if (conv_busy === 1'b1 && busy_prev === 1'b0) begin
      n_conv++;
      if (armed) begin
        gmin <= (gap < gmin) ? gap : gmin;
        gmax <= (gap > gmax) ? gap : gmax;
        armed <= 1'b0;
      end
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // one frame; q holds the returned word
  task automatic dev(input logic [15:0] cmd, input logic [15:0] d);
    int k;
    bus(1'b1, rtmsq_pkg::H_WDATA, {16'h0000, d});
    bus(1'b1, rtmsq_pkg::H_CMD, {16'h0000, cmd});
    for (k = 0; k < 1000; k++) begin
      rd(rtmsq_pkg::H_STAT);
      if (q[0] === 1'b0) break;
    end
    rd(rtmsq_pkg::H_RDATA);
  endtask
  task automatic wait_ready;
    int k;
    for (k = 0; k < 30; k++) begin
      dev({10'h200, rtmsq_pkg::REG_STAT}, 16'h0);
      if (q[4] === 1'b1) break;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge hclk);
    bad_count++;
    $display("watchdog expired");
    close_out();
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    touch_n = 1'b1;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("ss_n", 1'b1, link_if.ss_n) // idle select
    `CHK("pen", 1'b1, link_if.pen_touch_data_ready_out) // no touch
    dev({10'h200, rtmsq_pkg::REG_DELAY}, 16'h0);
    `CHK("delay rst", rtmsq_pkg::DELAY_RST, q[15:0]) // reset value
    dev({10'h000, rtmsq_pkg::REG_DELAY}, DLY);
    dev({10'h000, rtmsq_pkg::REG_CTRL}, 16'h0002);
    dev({10'h200, rtmsq_pkg::REG_DELAY}, 16'h0);
    `CHK("delay", DLY, q[15:0]) // read back
    dev({10'h200, rtmsq_pkg::REG_CTRL}, 16'h0);
    `CHK("ctrl", 16'h0002, q[15:0]) // host mode
    $display("test registers done");
    rd(rtmsq_pkg::H_IRQ_STAT);
    `CHK("irq stat", 1'b1, q[0])
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, rtmsq_pkg::H_IRQ_EN, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK("irq on", 1'b1, irq)
    bus(1'b1, rtmsq_pkg::H_IRQ_CLR, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK("irq off", 1'b0, irq)
    $display("test interrupt done");
    order_q.delete();
    c0 = n_conv;
    dev({10'h000, rtmsq_pkg::REG_CMD}, rtmsq_pkg::CMD_SCAN);
    wait_ready();
    `CHK("conv count", c0 + 4, n_conv) // x, y and two pressure
    `CHK("drive count", 3, order_q.size()) // axis order
    for (i = 0; i < 3; i++) `CHK("drive order", ord[i], order_q[i]) // y first
    for (i = 0; i < 4; i++) begin
      dev({10'h200, regs[i]}, 16'h0);
      `CHK("result", {4'h0, vals[i]}, q[15:0]) // axis routing
    end
    `CHK("settle min", 1'b1, gmin >= DLY * rtmsq_pkg::TICK_CYC - 2) // delay kept
    `CHK("settle max", 1'b1, gmax <= DLY * rtmsq_pkg::TICK_CYC + 8) // expiry starts
    $display("test scan done");
    for (i = 0; i < 2; i++) begin
      dev({10'h000, rtmsq_pkg::REG_STAT}, 16'h0);
      c0 = n_conv;
      dev({10'h000, rtmsq_pkg::REG_CMD}, dcmd[i]);
      repeat (60) @(posedge hclk);
      `CHK("drive only", dsel[i], drive_sel) // drivers on
      `CHK("no conv", c0, n_conv) // nothing started
      dev({10'h000, rtmsq_pkg::REG_CMD}, rtmsq_pkg::CMD_CONV); // after settling
      wait_ready();
      `CHK("one conv", c0 + 1, n_conv) // held axis only
      dev({10'h200, regs[i]}, 16'h0);
      `CHK("held result", {4'h0, vals[i]}, q[15:0]) // held axis
    end
    $display("test drivers only done");
    dev({10'h000, rtmsq_pkg::REG_CTRL}, 16'h0001);
    dev({10'h000, rtmsq_pkg::REG_STAT}, 16'h0);
    c0 = n_conv;
    touch_n <= 1'b0;
    repeat (200) @(posedge hclk);
    `CHK("pen low", 1'b0, link_if.pen_touch_data_ready_out) // pen signal
    `CHK("no auto", c0, n_conv) // host starts
    dev({10'h000, rtmsq_pkg::REG_CTRL}, RES_8); // touch start; resolution field set to 8-bit, which the device does not decode
    wait_ready();
    `CHK("auto scan", 1'b1, n_conv >= c0 + 4) // touch starts
    touch_n <= 1'b1;
    $display("test modes done");
    close_out();
  end
endmodule
